// [ucm_channel_ctrl.sv]
// channel control: mode, rts/cts handling, stop length, clock selects, command execution
// assumes an avalon-mm master with word addresses and a transmitter shifter outside
//
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/100ps
module ucm_channel_ctrl
    import ucm_pkg::*;
(
    input wire logic clk, // system clock, 50 MHz
    input wire logic rst_n, // async reset, active low
    input wire logic [3:0] avs_address, // word address
    input wire logic avs_read, // read request
    input wire logic avs_write, // write request
    input wire logic [31:0] avs_writedata, // write data
    input wire logic [3:0] avs_byteenable, // byte lanes
    output logic [31:0] avs_readdata, // read data
    output logic avs_waitrequest, // stall
    output ucm_mode_t chan_mode, // channel mode
    output logic echo_en, // automatic echo active
    output logic local_loop_en, // local loopback active
    output logic remote_loop_en, // remote loopback active
    output logic tx_rts_ctrl, // transmitter owns rts
    output logic cts_gate_en, // transmission waits for cts
    input wire logic cts_n, // clear-to-send, active low
    output logic tx_permit, // transmitter may start a character
    output logic [3:0] rx_clk_sel, // receiver clock select
    output logic [3:0] tx_clk_sel, // transmitter clock select
    output logic rx_enable, // receiver enabled
    output logic tx_enable, // transmitter enabled
    output logic [3:0] misc_cmd, // miscellaneous command code
    output logic misc_cmd_valid, // one-cycle command pulse
    output logic [7:0] tx_data, // character for the shifter
    output logic tx_data_valid, // character waiting
    input wire logic tx_data_ready, // shifter takes character
    input wire logic tx_stop_start, // shifter begins stop interval
    input wire logic tick16, // sixteen-times bit rate enable
    output logic tx_stop_done, // stop interval over
    output logic [4:0] tx_stop_len // stop interval in sixteenths
);

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic [7:0] mode2;
        logic [7:0] baud;
        logic [1:0] fmt;
        logic rx_en;
        logic tx_en;
        logic [3:0] misc;
        logic misc_vld;
        logic [7:0] txd;
        logic txd_vld;
        logic refused;
    } ucm_regs_t;

    ucm_regs_t q_reg;
    ucm_regs_t q_next;

    logic req;
    logic take;
    logic lane0;
    logic [7:0] wbyte;
    logic five_bits;

    ucm_stop_if sif ();

    // bus handshake: one wait cycle per access, then the access takes effect
    assign req = avs_read | avs_write;
    assign take = req & q_reg.ack;
    assign avs_waitrequest = req & ~q_reg.ack;
    assign lane0 = avs_byteenable[0];
    assign wbyte = avs_writedata[7:0];
    assign five_bits = q_reg.fmt == `UCM_FMT_FIVE;

    // register and command logic
    always_comb begin
        q_next = q_reg;
        q_next.ack = req & ~q_reg.ack;
        q_next.misc_vld = 1'b0;
        // character leaves when the shifter takes it
        if (q_reg.txd_vld && tx_data_ready) begin
            q_next.txd_vld = 1'b0;
        end
        // read data are captured in the wait cycle and stand at the taking edge
        if (avs_read && !q_reg.ack) begin
            q_next.rdata = 32'h0000_0000;
            unique case (avs_address)
                `UCM_IDX_MODE_TWO: q_next.rdata[7:0] = q_reg.mode2;
                `UCM_IDX_STATUS: begin
                    q_next.rdata[`UCM_ST_RX_EN] = q_reg.rx_en;
                    q_next.rdata[`UCM_ST_TX_EN] = q_reg.tx_en;
                    q_next.rdata[`UCM_ST_HOLD_FULL] = q_reg.txd_vld;
                    q_next.rdata[`UCM_ST_REFUSED] = q_reg.refused;
                end
                `UCM_IDX_FORMAT: q_next.rdata[1:0] = q_reg.fmt;
                default: q_next.rdata = 32'h0000_0000;
            endcase
        end
        // status read clears the refused flag
        if (avs_read && take && avs_address == `UCM_IDX_STATUS) begin
            q_next.refused = 1'b0;
        end
        if (avs_write && take && lane0) begin
            unique case (avs_address)
                `UCM_IDX_MODE_TWO: q_next.mode2 = wbyte;
                `UCM_IDX_BAUD_SEL: q_next.baud = wbyte;
                `UCM_IDX_FORMAT: q_next.fmt = wbyte[1:0];
                `UCM_IDX_COMMAND: begin
                    if (wbyte[`UCM_CMD_RX_DIS]) begin
                        q_next.rx_en = 1'b0;
                    end else if (wbyte[`UCM_CMD_RX_EN]) begin
                        q_next.rx_en = 1'b1;
                    end
                    if (wbyte[`UCM_CMD_TX_DIS]) begin
                        q_next.tx_en = 1'b0;
                    end else if (wbyte[`UCM_CMD_TX_EN]) begin
                        q_next.tx_en = 1'b1;
                    end
                    q_next.misc = wbyte[`UCM_CMD_MISC_HI:`UCM_CMD_MISC_LO];
                    q_next.misc_vld = ucm_is_misc(wbyte);
                end
                `UCM_IDX_TX_HOLD: begin
                    if (q_reg.tx_en && !q_reg.txd_vld) begin
                        q_next.txd = wbyte;
                        q_next.txd_vld = 1'b1;
                    end else begin
                        q_next.refused = 1'b1;
                    end
                end
                default: q_next.mode2 = q_reg.mode2;
            endcase
        end
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q_reg <= '{ack: 1'b0, rdata: 32'h0000_0000, mode2: `UCM_RST_MODE_TWO,
                       baud: `UCM_RST_BAUD_SEL, fmt: `UCM_RST_FORMAT, rx_en: 1'b0,
                       tx_en: 1'b0, misc: 4'h0, misc_vld: 1'b0, txd: 8'h00,
                       txd_vld: 1'b0, refused: 1'b0};
        end else begin
            q_reg <= q_next;
        end
    end

    // mode decode
    assign chan_mode = ucm_mode_t'(q_reg.mode2[`UCM_M2_MODE_HI:`UCM_M2_MODE_LO]);
    assign echo_en = chan_mode == UCM_MODE_ECHO;
    assign local_loop_en = chan_mode == UCM_MODE_LOCAL;
    assign remote_loop_en = chan_mode == UCM_MODE_REMOTE;

    // rts and cts handling
    assign tx_rts_ctrl = q_reg.mode2[`UCM_M2_RTS_BIT];
    assign cts_gate_en = q_reg.mode2[`UCM_M2_CTS_BIT];
    assign tx_permit = q_reg.tx_en & (~cts_gate_en | ~cts_n);

    // clock selects, enables and outputs
    assign rx_clk_sel = q_reg.baud[`UCM_BS_RX_HI:`UCM_BS_RX_LO];
    assign tx_clk_sel = q_reg.baud[`UCM_BS_TX_HI:`UCM_BS_TX_LO];
    assign rx_enable = q_reg.rx_en;
    assign tx_enable = q_reg.tx_en;
    assign misc_cmd = q_reg.misc;
    assign misc_cmd_valid = q_reg.misc_vld;
    assign tx_data = q_reg.txd;
    assign tx_data_valid = q_reg.txd_vld;
    assign avs_readdata = q_reg.rdata;

    // stop interval length and timer
    assign tx_stop_len = ucm_stop_len(q_reg.mode2[`UCM_M2_STOP_HI:`UCM_M2_STOP_LO], five_bits);
    assign sif.start = tx_stop_start;
    assign sif.tick16 = tick16;
    assign sif.length = tx_stop_len;
    assign tx_stop_done = sif.done;

    ucm_stop_timer u_stop (
        .clk(clk),
        .rst_n(rst_n),
        .sif(sif)
    );

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    logic mode_wr;
    logic cmd_wr;
    logic hold_wr;
    assign mode_wr = avs_write & take & lane0 & (avs_address == `UCM_IDX_MODE_TWO);
    assign cmd_wr = avs_write & take & lane0 & (avs_address == `UCM_IDX_COMMAND);
    assign hold_wr = avs_write & take & lane0 & (avs_address == `UCM_IDX_TX_HOLD);

    property p_mode_decode;
        mode_wr |=> (chan_mode == $past(avs_writedata[7:6]))
            && (local_loop_en == ($past(avs_writedata[7:6]) == 2'b10))
            && (remote_loop_en == ($past(avs_writedata[7:6]) == 2'b11));
    endproperty
    a_mode_decode: assert property (p_mode_decode) else $error("mode decode wrong");

    property p_stop_len;
        !five_bits |-> tx_stop_len == (q_reg.mode2[3] ? 5'd17 : 5'd9) + {1'b0, q_reg.mode2[3:0]};
    endproperty
    a_stop_len: assert property (p_stop_len) else $error("stop length wrong");

    property p_stop_five;
        five_bits && !q_reg.mode2[3] |-> tx_stop_len == 5'd17 + {2'b0, q_reg.mode2[2:0]};
    endproperty
    a_stop_five: assert property (p_stop_five) else $error("five-bit stop length wrong");

    property p_rts_ctrl;
        mode_wr |=> tx_rts_ctrl == $past(avs_writedata[5]);
    endproperty
    a_rts_ctrl: assert property (p_rts_ctrl) else $error("rts control not following setting");

    property p_cts_gate;
        tx_permit |-> tx_enable && (!cts_gate_en || !cts_n);
    endproperty
    a_cts_gate: assert property (p_cts_gate) else $error("transmit permitted without cts");

    property p_refuse;
        hold_wr && !tx_enable |=> !tx_data_valid || $past(tx_data_valid) && $stable(tx_data);
    endproperty
    a_refuse: assert property (p_refuse) else $error("disabled transmitter was loaded");

    property p_cmd_enable;
        cmd_wr && avs_writedata[2] && !avs_writedata[3] |=> tx_enable ##1 tx_enable || $past(cmd_wr);
    endproperty
    a_cmd_enable: assert property (p_cmd_enable) else $error("transmitter enable not taken");

    property p_cmd_hold;
        cmd_wr && avs_writedata[1:0] == 2'b00 |=> $stable(rx_enable);
    endproperty
    a_cmd_hold: assert property (p_cmd_hold) else $error("receiver state changed without command");

    c_load: cover property (hold_wr && tx_enable ##1 tx_data_valid);
    c_refused: cover property (hold_wr && !tx_enable);
    c_remote: cover property (mode_wr ##1 remote_loop_en);
    c_stop_done: cover property (tx_stop_done && five_bits);

endmodule

// [ucm_map.svh]
// register offsets, field positions, reset values and timing counts of the channel control block
// assumes a 32-bit avalon-mm slave with word addressing (byte address is four times the index)
`ifndef UCM_MAP_SVH
`define UCM_MAP_SVH

// register indices (word addresses)
`define UCM_IDX_MODE_TWO 4'h0
`define UCM_IDX_COMMAND 4'h1
`define UCM_IDX_BAUD_SEL 4'h2
`define UCM_IDX_STATUS 4'h3
`define UCM_IDX_TX_HOLD 4'h4
`define UCM_IDX_FORMAT 4'h5

// channel_mode_two fields
`define UCM_M2_MODE_HI 7
`define UCM_M2_MODE_LO 6
`define UCM_M2_RTS_BIT 5
`define UCM_M2_CTS_BIT 4
`define UCM_M2_STOP_HI 3
`define UCM_M2_STOP_LO 0

// channel_command fields
`define UCM_CMD_RX_EN 0
`define UCM_CMD_RX_DIS 1
`define UCM_CMD_TX_EN 2
`define UCM_CMD_TX_DIS 3
`define UCM_CMD_MISC_HI 7
`define UCM_CMD_MISC_LO 4

// baud_clock_select fields
`define UCM_BS_RX_HI 7
`define UCM_BS_RX_LO 4
`define UCM_BS_TX_HI 3
`define UCM_BS_TX_LO 0

// format field: character length code, 00 means five bits
`define UCM_FMT_FIVE 2'h0

// status bits
`define UCM_ST_RX_EN 0
`define UCM_ST_TX_EN 1
`define UCM_ST_HOLD_FULL 2
`define UCM_ST_REFUSED 3

// reset values
`define UCM_RST_MODE_TWO 8'h00
`define UCM_RST_BAUD_SEL 8'h00
`define UCM_RST_FORMAT 2'h3

// stop interval in sixteenths of a bit
`define UCM_STOP_BASE_LO 5'h09
`define UCM_STOP_BASE_HI 5'h19
`define UCM_STOP_FIVE_ADD 5'h08
`define UCM_MISC_GAP 3

`endif

// [ucm_pkg.sv]
// types and shared decode functions of the channel control block
// assumes ucm_map.svh is on the include path
`include "ucm_map.svh"
package ucm_pkg;

    typedef enum logic [1:0] {
        UCM_MODE_NORMAL = 2'b00,
        UCM_MODE_ECHO = 2'b01,
        UCM_MODE_LOCAL = 2'b10,
        UCM_MODE_REMOTE = 2'b11
    } ucm_mode_t;

    typedef enum logic {
        UCM_TMR_IDLE = 1'b0,
        UCM_TMR_RUN = 1'b1
    } ucm_tmr_state_t;

    // stop interval in sixteenth-bit steps from code and five-bit flag
    // code f reaches 32 sixteenths and wraps to 0, which the timer counts as 32
    function automatic logic [4:0] ucm_stop_len(input logic [3:0] code, input logic five);
        logic [4:0] len;
        len = 5'h00;
        if (!code[3]) begin
            len = `UCM_STOP_BASE_LO + {2'h0, code[2:0]};
            if (five) begin
                len = len + `UCM_STOP_FIVE_ADD;
            end
        end else begin
            len = `UCM_STOP_BASE_HI + {2'h0, code[2:0]};
        end
        return len;
    endfunction

    // true when the command register write carries a nonzero miscellaneous code
    function automatic logic ucm_is_misc(input logic [7:0] cmd);
        return cmd[`UCM_CMD_MISC_HI:`UCM_CMD_MISC_LO] != 4'h0;
    endfunction

endpackage

// [ucm_stop_if.sv]
// carrier between the channel control and its stop interval timer
// assumes one clock shared by both ends
`timescale 1ns/100ps
interface ucm_stop_if;
    logic start;
    logic tick16;
    logic [4:0] length;
    logic done;
    modport ctrl (output start, output tick16, output length, input done);
    modport timer (input start, input tick16, input length, output done);
endinterface

// [ucm_stop_timer.sv]
// stop interval timer: counts sixteenth-bit ticks after start, pulses done at the end
// assumes tick16 is a one-cycle enable at sixteen times the bit rate
`timescale 1ns/100ps
module ucm_stop_timer
    import ucm_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic rst_n, // async reset, active low
    ucm_stop_if.timer sif // start, tick, length and done
);

    typedef struct packed {
        ucm_tmr_state_t st;
        logic [4:0] cnt;
        logic done;
    } ucm_tmr_regs_t;

    ucm_tmr_regs_t q_reg;
    ucm_tmr_regs_t q_next;

    // count ticks down from the loaded length
    always_comb begin
        q_next = q_reg;
        q_next.done = 1'b0;
        unique case (q_reg.st)
            UCM_TMR_IDLE: begin
                if (sif.start) begin
                    q_next.st = UCM_TMR_RUN;
                    q_next.cnt = sif.length;
                end
            end
            UCM_TMR_RUN: begin
                if (sif.tick16) begin
                    q_next.cnt = q_reg.cnt - 5'h01;
                    if (q_reg.cnt == 5'h01) begin
                        q_next.st = UCM_TMR_IDLE;
                        q_next.done = 1'b1;
                    end
                end
            end
        endcase
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q_reg <= '{st: UCM_TMR_IDLE, cnt: 5'h00, done: 1'b0};
        end else begin
            q_reg <= q_next;
        end
    end

    assign sif.done = q_reg.done;

    // ticks seen since start, for checking only
    logic [5:0] chk_ticks_reg;
    logic [4:0] chk_len_reg;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chk_ticks_reg <= 6'h00;
            chk_len_reg <= 5'h00;
        end else if (q_reg.st == UCM_TMR_IDLE && sif.start) begin
            chk_ticks_reg <= 6'h00;
            chk_len_reg <= sif.length;
        end else if (q_reg.st == UCM_TMR_RUN && sif.tick16) begin
            chk_ticks_reg <= chk_ticks_reg + 6'h01;
        end
    end

    // a length of zero wraps the down counter and lasts 32 ticks
    property p_stop_ticks;
        @(posedge clk) disable iff (!rst_n)
        $rose(q_reg.done) |-> chk_ticks_reg == ((chk_len_reg == 5'h00) ? 6'h20 : {1'b0, chk_len_reg});
    endproperty
    a_stop_ticks: assert property (p_stop_ticks) else $error("stop interval tick count wrong");

endmodule

// [ucm_shifter_model.sv]
// behavioural transmit shifter facing the channel control block
// assumes the control block holds tx_data_valid until a valid and ready edge
`timescale 1ns/100ps
module ucm_shifter_model (
    input wire logic clk, // system clock
    input wire logic rst_n, // async reset, active low
    input wire logic slow, // 1 delays ready by several cycles
    input wire logic [7:0] tx_data, // offered character
    input wire logic tx_data_valid, // character offered
    input wire logic tx_permit, // transmitter may start
    output logic tx_data_ready, // takes the character
    output logic tx_stop_start, // stop interval begins
    output logic tick16, // 16x enable, one cycle in four
    output logic [7:0] last_char, // last character taken
    output logic [7:0] char_count // characters taken
);
    logic [1:0] tdiv_reg;
    logic [2:0] wait_reg;
    logic pend_reg;

    // tick every fourth cycle; starts land between ticks
    assign tick16 = (tdiv_reg == 2'h0);

    // ready only while permitted, later when slow
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tdiv_reg <= 2'h0;
            wait_reg <= 3'h0;
            pend_reg <= 1'b0;
            tx_data_ready <= 1'b0;
            tx_stop_start <= 1'b0;
            last_char <= 8'h00;
            char_count <= 8'h00;
        end else begin
            tdiv_reg <= tdiv_reg + 2'h1;
            tx_stop_start <= 1'b0;
            if (tx_data_valid && tx_data_ready) begin
                last_char <= tx_data;
                char_count <= char_count + 8'h01;
                tx_data_ready <= 1'b0;
                pend_reg <= 1'b1;
                wait_reg <= 3'h0;
            end else if (tx_data_valid && tx_permit && !tx_data_ready) begin
                wait_reg <= wait_reg + 3'h1;
                tx_data_ready <= !slow || (wait_reg == 3'h5);
            end
            if (pend_reg && tdiv_reg == 2'h2) begin
                tx_stop_start <= 1'b1;
                pend_reg <= 1'b0;
            end
        end
    end
endmodule

// [ucm_channel_ctrl_test.sv]
// self-checking bench of the channel control block with a shifter model
// assumes ucm_map.svh on the include path and the design compiled first
`timescale 1ns/100ps
`include "ucm_map.svh"
module ucm_channel_ctrl_test;
    typedef struct {logic [7:0] m2; logic [1:0] fmt; logic [7:0] bs; logic [4:0] len;} ucm_row_t;
    ucm_row_t rows [8] = '{'{8'h00, 2'h3, 8'h12, 5'h09}, '{8'h67, 2'h3, 8'h34, 5'h10},
        '{8'hb8, 2'h3, 8'h56, 5'h19}, '{8'hdb, 2'h3, 8'h78, 5'h1c}, '{8'h00, 2'h0, 8'h9a, 5'h11},
        '{8'h07, 2'h0, 8'hbc, 5'h18}, '{8'h08, 2'h0, 8'hde, 5'h19}, '{8'h0b, 2'h1, 8'hf0, 5'h1c}};
    logic [7:0] cmds [7] = '{8'h01, 8'h04, 8'h00, 8'h02, 8'h0c, 8'h05, 8'h0f};
    logic [1:0] ens [7] = '{2'h1, 2'h3, 2'h3, 2'h2, 2'h0, 2'h3, 2'h0}; // {tx, rx}
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [3:0] be = 4'hf;
    logic cts_n = 1'b1;
    logic slow = 1'b0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, echo_en, local_loop_en, remote_loop_en, tx_rts_ctrl, cts_gate_en, tx_permit;
    logic rx_enable, tx_enable, misc_cmd_valid, tx_data_valid, tx_data_ready, tx_stop_start, tick16;
    logic tx_stop_done, run;
    logic [1:0] chan_mode;
    logic [3:0] rx_clk_sel, tx_clk_sel, misc_cmd;
    logic [7:0] tx_data, rd, last_char, char_count;
    logic [4:0] tx_stop_len;
    int err_count = 0;
    int total_checks = 0;
    int misc_seen = 0;
    int tick_cnt = 0;
    int got_ticks = -1;
    int s;

    ucm_channel_ctrl ucm_channel_ctrl_i (.clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .chan_mode, .echo_en, .local_loop_en,
        .remote_loop_en, .tx_rts_ctrl, .cts_gate_en, .cts_n, .tx_permit, .rx_clk_sel, .tx_clk_sel,
        .rx_enable, .tx_enable, .misc_cmd, .misc_cmd_valid, .tx_data, .tx_data_valid, .tx_data_ready,
        .tx_stop_start, .tick16, .tx_stop_done, .tx_stop_len);
    ucm_shifter_model ucm_shifter_model_i (.clk, .rst_n, .slow, .tx_data, .tx_data_valid, .tx_permit,
        .tx_data_ready, .tx_stop_start, .tick16, .last_char, .char_count);

    // 50 MHz clock
    always #10 clk = ~clk;

    // counts command pulses and ticks inside each stop interval
    always @(posedge clk) begin
        if (misc_cmd_valid === 1'b1) misc_seen <= misc_seen + 1;
        if (tx_stop_start === 1'b1) begin
            run <= 1'b1;
            tick_cnt <= 0;
        end else if (run === 1'b1 && tick16 === 1'b1) tick_cnt <= tick_cnt + 1;
        if (run === 1'b1 && tx_stop_done === 1'b1) begin
            got_ticks <= tick_cnt;
            run <= 1'b0;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one bus access, held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
        int k;
        k = 0;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0 && k < 20) begin
            @(posedge clk);
            k++;
        end
        chk(k < 20, 1'b1);
        rd = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        // let the access settle before callers look at outputs
        @(posedge clk);
    endtask

    task automatic waitfor(input logic [7:0] cnt);
        got_ticks = -1;
        for (int k = 0; k < 200 && (char_count !== cnt || got_ticks < 0); k++) @(posedge clk);
    endtask

    task automatic done_test(input string name);
        $display("test %s ended, errors %0d", name, err_count);
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // watchdog against a hung handshake
    initial begin
        #(20 * 30000);
        err_count++;
        close_out;
    end

    // main sequence
    initial begin
        repeat (8) @(negedge clk);
        chk(tx_stop_len, 5'h09);
        chk({rx_enable, tx_enable, tx_permit}, 3'h0);
        @(posedge clk);
        rst_n <= 1'b1;
        bus(0, `UCM_IDX_MODE_TWO, 8'h00);
        chk(rd, 8'h00);
        bus(0, `UCM_IDX_FORMAT, 8'h00);
        chk(rd, 8'h03);
        bus(0, `UCM_IDX_COMMAND, 8'h00);
        chk(rd, 8'h00);
        done_test("reset");
        foreach (rows[i]) begin
            bus(1, `UCM_IDX_FORMAT, {6'h0, rows[i].fmt});
            bus(1, `UCM_IDX_MODE_TWO, rows[i].m2);
            bus(1, `UCM_IDX_BAUD_SEL, rows[i].bs);
            bus(0, `UCM_IDX_MODE_TWO, 8'h00);
            chk(rd, rows[i].m2);
            chk(chan_mode, rows[i].m2[7:6]);
            chk({echo_en, local_loop_en, remote_loop_en}, {rows[i].m2[7:6] == 2'b01,
                rows[i].m2[7:6] == 2'b10, rows[i].m2[7:6] == 2'b11});
            chk(tx_rts_ctrl, rows[i].m2[5]);
            chk(cts_gate_en, rows[i].m2[4]);
            chk(tx_stop_len, rows[i].len);
            chk({rx_clk_sel, tx_clk_sel}, rows[i].bs);
        end
        done_test("rows");
        be = 4'he;
        bus(1, `UCM_IDX_MODE_TWO, 8'hff);
        be = 4'hf;
        bus(0, `UCM_IDX_MODE_TWO, 8'h00);
        chk(rd, 8'h0b);
        bus(1, 4'hf, 8'hff);
        bus(0, 4'hf, 8'h00);
        chk(rd, 8'h00);
        done_test("refused access");
        foreach (cmds[i]) begin
            bus(1, `UCM_IDX_COMMAND, cmds[i]);
            chk({tx_enable, rx_enable}, ens[i]);
            bus(0, `UCM_IDX_STATUS, 8'h00);
            chk(rd[1:0], ens[i]);
        end
        done_test("command");
        bus(1, `UCM_IDX_TX_HOLD, 8'h5a);
        chk(tx_data_valid, 1'b0);
        bus(0, `UCM_IDX_STATUS, 8'h00);
        chk(rd[3:2], 2'h2);
        chk(char_count, 8'h00);
        done_test("disabled load");
        bus(1, `UCM_IDX_FORMAT, 8'h03);
        bus(1, `UCM_IDX_MODE_TWO, 8'h17);
        bus(1, `UCM_IDX_COMMAND, 8'h05);
        slow <= 1'b1;
        bus(1, `UCM_IDX_TX_HOLD, 8'ha5);
        repeat (10) @(posedge clk);
        chk({tx_permit, tx_data_valid, char_count}, {2'h1, 8'h00});
        cts_n <= 1'b0;
        waitfor(8'h01);
        chk(last_char, 8'ha5);
        chk(got_ticks, 16);
        bus(1, `UCM_IDX_FORMAT, 8'h00);
        bus(1, `UCM_IDX_MODE_TWO, 8'h00);
        slow <= 1'b0;
        cts_n <= 1'b1;
        bus(1, `UCM_IDX_TX_HOLD, 8'h3c);
        waitfor(8'h02);
        chk(last_char, 8'h3c);
        chk(got_ticks, 17);
        done_test("transmit");
        s = misc_seen;
        bus(1, `UCM_IDX_COMMAND, 8'h30);
        bus(1, `UCM_IDX_COMMAND, 8'ha0);
        repeat (2) @(posedge clk);
        chk(misc_seen - s, 2);
        chk(misc_cmd, 4'ha);
        chk({tx_enable, rx_enable}, 2'h3);
        done_test("misc command");
        rst_n <= 1'b0;
        @(posedge clk);
        chk({tx_enable, rx_enable, tx_data_valid, misc_cmd}, 7'h00);
        rst_n <= 1'b1;
        bus(0, `UCM_IDX_FORMAT, 8'h00);
        chk(rd, `UCM_RST_FORMAT);
        done_test("mid-run reset");
        close_out;
    end
endmodule
